// ==== design/mic_irq_ctrl.sv ====
/*
  Interrupt controller top: request flags, enables, edge detect on the
  external pin, fixed priority selection, service sequencer and an APB
  slave for the five interrupt registers.
  Assumes peripheral events are one-cycle pulses on REF_CLK, the external
  pin is asynchronous, and the core reports stack full and return from
  interrupt on REF_CLK and obeys the push, load and pop strobes.
*/
`timescale 1ns/10ps

module mic_irq_ctrl
(
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic CE,
  // APB slave.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [mic_pkg::APB_AW-1:0] PADDR,
  input wire logic [mic_pkg::APB_DW-1:0] PWDATA,
  output logic [mic_pkg::APB_DW-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Event sources.
  input wire logic EXT_PIN,
  input wire logic TICK0_EVT,
  input wire logic TICK1_EVT,
  input wire logic CONV_DONE,
  input wire logic NVM_DONE,
  input wire mic_pkg::mic_cmp_evt_s CMP_EVT,
  // Core side.
  input wire logic [mic_pkg::PC_W-1:0] CORE_NEXT_PC,
  input wire logic STACK_FULL,
  input wire logic RETI_EXEC,
  output mic_pkg::mic_core_cmd_s CORE_CMD,
  output logic WAKE
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  // Pin synchroniser stages and the previous synced level.
  logic pin_meta_reg;
  logic pin_sync_reg;
  logic pin_prev_reg;
  // Edge select field.
  logic [1:0] edge_sel_reg;
  // Vectored source flags and enables, indexed by source.
  logic [mic_pkg::NSRC-1:0] flag_reg;
  logic [mic_pkg::NSRC-1:0] enable_reg;
  // Global enable.
  logic gie_reg;
  // Timer compare flags and enables.
  logic [mic_pkg::NCMP-1:0] cmp_flag_reg;
  logic [mic_pkg::NCMP-1:0] cmp_en_reg;
  // Sequencer state and the captured service data.
  mic_pkg::mic_seq_e seq_reg;
  mic_pkg::mic_seq_e seq_next;
  logic [mic_pkg::PC_W-1:0] saved_pc_reg;
  logic [mic_pkg::PC_W-1:0] vec_addr_reg;
  logic pop_reg;
  logic wake_reg;
  // Read data and error captured in the setup phase.
  logic [mic_pkg::APB_DW-1:0] rdata_reg;
  logic err_reg;

  // Combinational helpers.
  logic pin_evt;
  logic [mic_pkg::NSRC-1:0] src_evt;
  logic [mic_pkg::NCMP-1:0] cmp_evt;
  logic [mic_pkg::NSRC-1:0] pending;
  logic [mic_pkg::NSRC-1:0] svc_onehot;
  logic [2:0] svc_idx;
  logic take;
  logic access;
  logic hit_edge;
  logic hit_ctrl0;
  logic hit_ctrl1;
  logic hit_grp0;
  logic hit_grp1;
  logic hit_any;
  logic wr_ctrl0;
  logic wr_ctrl1;
  logic [mic_pkg::REG_W-1:0] rd_ctrl0;
  logic [mic_pkg::REG_W-1:0] rd_ctrl1;
  logic [mic_pkg::REG_W-1:0] rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // External pin: synchronise, then detect the selected edge.

  // Two flops guard against metastability; the third only holds history.
  always_ff @(posedge REF_CLK)
  begin
    if (!NRST)
    begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
      pin_prev_reg <= 1'b0;
    end
    else if (CE)
    begin
      pin_meta_reg <= EXT_PIN;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  // Decode of the edge field; the off code ignores the pin entirely.
  always_comb
  begin
    unique case (edge_sel_reg)
      mic_pkg::EDGE_OFF: pin_evt = 1'b0;
      mic_pkg::EDGE_RISE: pin_evt = pin_sync_reg & ~pin_prev_reg;
      mic_pkg::EDGE_FALL: pin_evt = ~pin_sync_reg & pin_prev_reg;
      mic_pkg::EDGE_BOTH: pin_evt = pin_sync_reg ^ pin_prev_reg;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source events per vector.

  // Compare events in index order; each timer feeds its own group.
  assign cmp_evt = CMP_EVT;

  // The group entries fire whenever one of their compares fires.
  always_comb
  begin
    src_evt = '0;
    src_evt[mic_pkg::SRC_PIN] = pin_evt;
    src_evt[mic_pkg::SRC_GROUP0] = |cmp_evt[1:0];
    src_evt[mic_pkg::SRC_TICK0] = TICK0_EVT;
    src_evt[mic_pkg::SRC_GROUP1] = |cmp_evt[3:2];
    src_evt[mic_pkg::SRC_CONV] = CONV_DONE;
    src_evt[mic_pkg::SRC_NVM] = NVM_DONE;
    src_evt[mic_pkg::SRC_TICK1] = TICK1_EVT;
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB decode.

  // The slave answers without wait states unless the block is frozen,
  // which keeps the master waiting rather than losing a write.
  assign PREADY = CE;
  assign access = PSEL & PENABLE & CE;
  assign hit_edge = (PADDR == mic_pkg::EDGE_SELECT_OFS);
  assign hit_ctrl0 = (PADDR == mic_pkg::PRIMARY_CTRL0_OFS);
  assign hit_ctrl1 = (PADDR == mic_pkg::PRIMARY_CTRL1_OFS);
  assign hit_grp0 = (PADDR == mic_pkg::GROUP0_OFS);
  assign hit_grp1 = (PADDR == mic_pkg::GROUP1_OFS);
  assign hit_any = hit_edge | hit_ctrl0 | hit_ctrl1 | hit_grp0 | hit_grp1;
  assign wr_ctrl0 = access & PWRITE & hit_ctrl0;
  assign wr_ctrl1 = access & PWRITE & hit_ctrl1;

  ////////////////////////////////////////////////////////////////////////////
  // Priority selection.

  // A source is pending only with its flag and its own enable set.
  assign pending = flag_reg & enable_reg;

  // Lowest index wins; exactly one source is chosen per service.
  always_comb
  begin
    svc_idx = 3'h0;
    for (int i = mic_pkg::NSRC - 1; i >= 0; i--)
    begin
      if (pending[i])
      begin
        svc_idx = i[2:0];
      end
    end
  end

  // Acknowledge only from idle, with global enable set and room on the
  // stack; a handler that sets the global enable again can be nested.
  assign take = (seq_reg == mic_pkg::SEQ_IDLE) & gie_reg & ~STACK_FULL
              & (|pending);
  assign svc_onehot = take ? (mic_pkg::NSRC'(1) << svc_idx) : '0;

  ////////////////////////////////////////////////////////////////////////////
  // Vectored flags and enables.

  genvar gi;
  generate
    for (gi = 0; gi < mic_pkg::NSRC; gi++)
    begin : g_src
      // A hardware set wins over both the service clear and a software
      // write, so an event landing in the clearing cycle is kept.
      always_ff @(posedge REF_CLK)
      begin
        if (!NRST)
        begin
          flag_reg[gi] <= 1'b0;
        end
        else if (CE)
        begin
          if (src_evt[gi])
          begin
            flag_reg[gi] <= 1'b1;
          end
          else if (svc_onehot[gi])
          begin
            // Group entries clear only themselves, never the compares.
            flag_reg[gi] <= 1'b0;
          end
          else if (mic_pkg::SRC_IN_CTRL1[gi] ? wr_ctrl1 : wr_ctrl0)
          begin
            flag_reg[gi] <= PWDATA[mic_pkg::SRC_FLAG_BIT[gi]];
          end
        end
      end

      // Enables change only by software.
      always_ff @(posedge REF_CLK)
      begin
        if (!NRST)
        begin
          enable_reg[gi] <= 1'b0;
        end
        else if (CE && (mic_pkg::SRC_IN_CTRL1[gi] ? wr_ctrl1 : wr_ctrl0))
        begin
          enable_reg[gi] <= PWDATA[mic_pkg::SRC_EN_BIT[gi]];
        end
      end
    end
  endgenerate

  // Global enable: the service clear wins over a software write in the
  // same cycle so that the handler always starts with it cleared.
  always_ff @(posedge REF_CLK)
  begin
    if (!NRST)
    begin
      gie_reg <= 1'b0;
    end
    else if (CE)
    begin
      if (take)
      begin
        gie_reg <= 1'b0;
      end
      else if (wr_ctrl0)
      begin
        gie_reg <= PWDATA[mic_pkg::GLOBAL_EN_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer compare flags, enables and the edge select field.

  // Compare flags are set by their match and cleared only by software.
  generate
    for (gi = 0; gi < mic_pkg::NCMP; gi++)
    begin : g_cmp
      always_ff @(posedge REF_CLK)
      begin
        if (!NRST)
        begin
          cmp_flag_reg[gi] <= 1'b0;
          cmp_en_reg[gi] <= 1'b0;
        end
        else if (CE)
        begin
          if (cmp_evt[gi])
          begin
            cmp_flag_reg[gi] <= 1'b1;
          end
          else if (access && PWRITE && (gi < 2 ? hit_grp0 : hit_grp1))
          begin
            cmp_flag_reg[gi] <= PWDATA[(gi % 2 == 1) ? mic_pkg::CMPA_FLAG_BIT
                                                      : mic_pkg::CMPP_FLAG_BIT];
          end
          if (access && PWRITE && (gi < 2 ? hit_grp0 : hit_grp1))
          begin
            cmp_en_reg[gi] <= PWDATA[(gi % 2 == 1) ? mic_pkg::CMPA_EN_BIT
                                                    : mic_pkg::CMPP_EN_BIT];
          end
        end
      end
    end
  endgenerate

  // Edge select is plain storage.
  always_ff @(posedge REF_CLK)
  begin
    if (!NRST)
    begin
      edge_sel_reg <= mic_pkg::REG_RESET[1:0];
    end
    else if (CE && access && PWRITE && hit_edge)
    begin
      edge_sel_reg <= PWDATA[mic_pkg::EDGE_SEL_LSB +: 2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Service sequencer.

  // Idle takes a request, push hands the return address to the stack,
  // jump loads the vector; the core is expected to honour each strobe.
  always_comb
  begin
    seq_next = seq_reg;
    unique case (seq_reg)
      mic_pkg::SEQ_IDLE:
      begin
        if (take)
        begin
          seq_next = mic_pkg::SEQ_PUSH;
        end
      end
      mic_pkg::SEQ_PUSH: seq_next = mic_pkg::SEQ_JUMP;
      mic_pkg::SEQ_JUMP: seq_next = mic_pkg::SEQ_IDLE;
      default: seq_next = mic_pkg::SEQ_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge REF_CLK)
  begin
    if (!NRST)
    begin
      seq_reg <= mic_pkg::SEQ_IDLE;
    end
    else if (CE)
    begin
      seq_reg <= seq_next;
    end
  end

  // Return address and vector are captured when the request is taken.
  always_ff @(posedge REF_CLK)
  begin
    if (!NRST)
    begin
      saved_pc_reg <= '0;
      vec_addr_reg <= '0;
    end
    else if (CE && take)
    begin
      saved_pc_reg <= CORE_NEXT_PC;
      vec_addr_reg <= mic_pkg::VEC_BASE
                    + mic_pkg::PC_W'(svc_idx) * mic_pkg::VEC_STRIDE;
    end
  end

  // Return from interrupt becomes one pop strobe.
  always_ff @(posedge REF_CLK)
  begin
    if (!NRST)
    begin
      pop_reg <= 1'b0;
    end
    else if (CE)
    begin
      pop_reg <= RETI_EXEC;
    end
  end

  // Push and load strobes are state decodes, the pop strobe is a flop; address fields come from flops.
  assign CORE_CMD.push_stb = (seq_reg == mic_pkg::SEQ_PUSH);
  assign CORE_CMD.push_pc = saved_pc_reg;
  assign CORE_CMD.load_stb = (seq_reg == mic_pkg::SEQ_JUMP);
  assign CORE_CMD.load_addr = vec_addr_reg;
  assign CORE_CMD.pop_stb = pop_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Wake-up.

  // Only a flag that goes from clear to set wakes the core; a flag that
  // software set beforehand suppresses a direct source's wake-up; a compare wakes unless both its own flag and its group flag are set.
  always_ff @(posedge REF_CLK)
  begin
    if (!NRST)
    begin
      wake_reg <= 1'b0;
    end
    else if (CE)
    begin
      wake_reg <= (|(src_evt & ~flag_reg))
                | (|(cmp_evt & ~cmp_flag_reg));
    end
  end
  assign WAKE = wake_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Read back.

  // Build the two control bytes from the per-source arrays.
  always_comb
  begin
    rd_ctrl0 = '0;
    rd_ctrl1 = '0;
    rd_ctrl0[mic_pkg::GLOBAL_EN_BIT] = gie_reg;
    for (int i = 0; i < mic_pkg::NSRC; i++)
    begin
      if (mic_pkg::SRC_IN_CTRL1[i])
      begin
        rd_ctrl1[mic_pkg::SRC_FLAG_BIT[i]] = flag_reg[i];
        rd_ctrl1[mic_pkg::SRC_EN_BIT[i]] = enable_reg[i];
      end
      else
      begin
        rd_ctrl0[mic_pkg::SRC_FLAG_BIT[i]] = flag_reg[i];
        rd_ctrl0[mic_pkg::SRC_EN_BIT[i]] = enable_reg[i];
      end
    end
  end

  // Address mux; unmapped addresses read zero.
  always_comb
  begin
    rd_mux = '0;
    if (hit_edge)
    begin
      rd_mux[mic_pkg::EDGE_SEL_LSB +: 2] = edge_sel_reg;
    end
    else if (hit_ctrl0)
    begin
      rd_mux = rd_ctrl0;
    end
    else if (hit_ctrl1)
    begin
      rd_mux = rd_ctrl1;
    end
    else if (hit_grp0 || hit_grp1)
    begin
      rd_mux[mic_pkg::CMPA_FLAG_BIT] = hit_grp0 ? cmp_flag_reg[1] : cmp_flag_reg[3];
      rd_mux[mic_pkg::CMPP_FLAG_BIT] = hit_grp0 ? cmp_flag_reg[0] : cmp_flag_reg[2];
      rd_mux[mic_pkg::CMPA_EN_BIT] = hit_grp0 ? cmp_en_reg[1] : cmp_en_reg[3];
      rd_mux[mic_pkg::CMPP_EN_BIT] = hit_grp0 ? cmp_en_reg[0] : cmp_en_reg[2];
    end
  end

  // Data and error are captured in the setup phase, so the access phase
  // presents flopped values; the flags shown are those at setup.
  always_ff @(posedge REF_CLK)
  begin
    if (!NRST)
    begin
      rdata_reg <= '0;
      err_reg <= 1'b0;
    end
    else if (CE && PSEL && !PENABLE)
    begin
      rdata_reg <= {{(mic_pkg::APB_DW - mic_pkg::REG_W){1'b0}}, rd_mux};
      err_reg <= ~hit_any;
    end
  end

  assign PRDATA = rdata_reg;
  assign PSLVERR = err_reg & PSEL & PENABLE;

endmodule

// ==== inc/mic_pkg.sv ====
/*
  Constants, types and register layout of the interrupt controller.
  Assumes one 25 MHz clock, a 32-bit APB register bus and a core that
  does the stack push, program counter load and pop when it is told to.
*/
// How it works
// - A source event sets its request flag.
// - A flag jumps only with its enable set.
// - Global enable at 0 blocks every jump.
// - Taking an interrupt pushes the next-instruction address first.
// - Then the counter loads the vector address.
// - Return-from-interrupt pops the saved program counter.
// - Servicing clears the global enable automatically.
// - Requests while disabled still set their flags.
// - Software re-enabling inside a handler permits nesting.
// - Full stack blocks acknowledging any request.
// - Any newly set flag wakes the device.
// - Edge select: off, rising, falling, both.
// - First control register layout, global enable bit 0.
// - Second control register: four flags, four enables.
// - Timer group register: compare flags 5,4, enables 1,0.
// - Unused bits read 0; set means pending/enabled.
// - Timer compares share a group vector.
// - Group flag sets on any included compare flag; here any compare match of its timer sets it and compare enables are ignored.
// - Group service clears group flag, not compare flags.
// - Servicing a direct source clears its own flag.
package mic_pkg;

  // Register bus widths.
  localparam int APB_AW = 8;
  localparam int APB_DW = 32;
  localparam int REG_W = 8;

  // Register byte addresses, one aligned word each.
  localparam logic [7:0] EDGE_SELECT_OFS = 8'h00;
  localparam logic [7:0] PRIMARY_CTRL0_OFS = 8'h04;
  localparam logic [7:0] PRIMARY_CTRL1_OFS = 8'h08;
  localparam logic [7:0] GROUP0_OFS = 8'h0C;
  localparam logic [7:0] GROUP1_OFS = 8'h10;

  // Reset value shared by all five registers.
  localparam logic [7:0] REG_RESET = 8'h00;

  // Edge select field and its codes.
  localparam int EDGE_SEL_LSB = 0;
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // Global enable position in the first control register.
  localparam int GLOBAL_EN_BIT = 0;

  // Vectored sources, index order is priority order (0 highest).
  localparam int NSRC = 7;
  localparam int SRC_PIN = 0;
  localparam int SRC_GROUP0 = 1;
  localparam int SRC_TICK0 = 2;
  localparam int SRC_GROUP1 = 3;
  localparam int SRC_CONV = 4;
  localparam int SRC_NVM = 5;
  localparam int SRC_TICK1 = 6;

  // Per source: 1 when it lives in the second control register.
  localparam logic [NSRC-1:0] SRC_IN_CTRL1 = 7'h78;
  // Per source flag and enable bit positions.
  localparam int SRC_FLAG_BIT [NSRC] = '{4, 6, 5, 4, 6, 5, 7};
  localparam int SRC_EN_BIT [NSRC] = '{1, 3, 2, 0, 2, 1, 3};

  // Timer compare sources: index 2*timer + (0 = P match, 1 = A match).
  localparam int NCMP = 4;
  localparam int CMPA_FLAG_BIT = 5;
  localparam int CMPP_FLAG_BIT = 4;
  localparam int CMPA_EN_BIT = 1;
  localparam int CMPP_EN_BIT = 0;

  // Program counter and vector table.
  localparam int PC_W = 12;
  localparam logic [PC_W-1:0] VEC_BASE = 12'h004;
  localparam logic [PC_W-1:0] VEC_STRIDE = 12'h004;

  // Service sequencer states.
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_PUSH = 2'b01,
    SEQ_JUMP = 2'b10
  } mic_seq_e;

  // Commands to the core's program counter and stack.
  typedef struct packed {
    logic push_stb;
    logic [PC_W-1:0] push_pc;
    logic load_stb;
    logic [PC_W-1:0] load_addr;
    logic pop_stb;
  } mic_core_cmd_s;

  // Timer compare match pulses.
  typedef struct packed {
    logic tmr1_cmpa;
    logic tmr1_cmpp;
    logic tmr0_cmpa;
    logic tmr0_cmpp;
  } mic_cmp_evt_s;

endpackage

// ==== verif/mic_core_model.sv ====
/*
  Behavioural model of the core side: stack depth, a moving next-PC and
  the return-from-interrupt strobe.
  Assumes the controller's push and pop strobes on REF_CLK.
*/
`timescale 1ns/10ps

module mic_core_model
#(
  parameter int DEPTH = 4
)
(
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire mic_pkg::mic_core_cmd_s CORE_CMD,
  input wire logic hold_full,
  input wire logic reti_req,
  output logic [mic_pkg::PC_W-1:0] CORE_NEXT_PC,
  output logic STACK_FULL,
  output logic RETI_EXEC
);
  logic [3:0] depth_reg; // Words held on the stack.

  // Depth follows pushes and pops.
  always_ff @(posedge REF_CLK)
  begin
    if (!NRST)
      depth_reg <= 4'h0;
    else if (CORE_CMD.push_stb)
      depth_reg <= depth_reg + 4'h1;
    else if (CORE_CMD.pop_stb && depth_reg != 4'h0)
      depth_reg <= depth_reg - 4'h1;
  end

  // Full either by depth or when the bench holds it, to stall acknowledge.
  assign STACK_FULL = hold_full || (depth_reg == 4'(DEPTH));

  // The PC moves every cycle so that a stale capture shows up.
  always_ff @(posedge REF_CLK)
  begin
    CORE_NEXT_PC <= NRST ? CORE_NEXT_PC + 12'h001 : 12'h100;
    RETI_EXEC <= NRST && reti_req;
  end
endmodule

// ==== verif/mic_irq_ctrl_monitor.sv ====
/*
  Checker on the controller ports: service strobes, return, wake and bus.
  Assumes one clock domain and that CE stays high while it judges.
*/
`timescale 1ns/10ps

module mic_irq_ctrl_monitor
(
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [mic_pkg::APB_AW-1:0] PADDR,
  input wire logic [mic_pkg::APB_DW-1:0] PRDATA,
  input wire logic PSLVERR,
  input wire logic EXT_PIN,
  input wire logic TICK0_EVT,
  input wire logic TICK1_EVT,
  input wire logic CONV_DONE,
  input wire logic NVM_DONE,
  input wire mic_pkg::mic_cmp_evt_s CMP_EVT,
  input wire logic [mic_pkg::PC_W-1:0] CORE_NEXT_PC,
  input wire logic STACK_FULL,
  input wire logic RETI_EXEC,
  input wire mic_pkg::mic_core_cmd_s CORE_CMD,
  input wire logic WAKE
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);
  wire logic evt = TICK0_EVT | TICK1_EVT | CONV_DONE | NVM_DONE | (|CMP_EVT);
  logic [2:0] pin_age; // Edges since the pin last moved, saturating.

  // Pin age lets a wake pulse blame a recent pin edge.
  always_ff @(posedge REF_CLK)
  begin
    if (!NRST || EXT_PIN != $past(EXT_PIN))
      pin_age <= 3'h0;
    else if (pin_age != 3'h7)
      pin_age <= pin_age + 3'h1;
  end

  sequence s_push; CORE_CMD.push_stb && CE; endsequence
  sequence s_load; ##1 CORE_CMD.load_stb ##1 !CORE_CMD.load_stb; endsequence
  property p_push_load; s_push |-> s_load; endproperty
  a_push_load: assert property (p_push_load) else $error("no load after push");
  property p_push_pc; s_push |-> CORE_CMD.push_pc == $past(CORE_NEXT_PC); endproperty
  a_push_pc: assert property (p_push_pc) else $error("pushed pc wrong");
  property p_full_block; $rose(CORE_CMD.push_stb) |-> !$past(STACK_FULL); endproperty
  a_full_block: assert property (p_full_block) else $error("push on full");
  property p_one_ack; s_push |=> !CORE_CMD.push_stb [*2]; endproperty
  a_one_ack: assert property (p_one_ack) else $error("push too soon");
  property p_vector;
    CORE_CMD.load_stb |-> CORE_CMD.load_addr[1:0] == 2'h0 &&
      CORE_CMD.load_addr >= 12'h004 && CORE_CMD.load_addr <= 12'h01C;
  endproperty
  a_vector: assert property (p_vector) else $error("vector out of table");
  property p_pop; RETI_EXEC && CE |=> CORE_CMD.pop_stb; endproperty
  a_pop: assert property (p_pop) else $error("no pop after return");
  property p_pop_only; CORE_CMD.pop_stb |-> $past(RETI_EXEC); endproperty
  a_pop_only: assert property (p_pop_only) else $error("pop without return");
  property p_wake; WAKE |-> $past(evt) || $past(evt, 2) || pin_age < 3'h7; endproperty
  a_wake: assert property (p_wake) else $error("wake without event");
  property p_bus;
    PSEL && PENABLE |-> PRDATA[31:8] == 24'h0 &&
      PSLVERR == !(PADDR inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10});
  endproperty
  a_bus: assert property (p_bus) else $error("bad bus answer");
  c_push: cover property (s_push);
endmodule

bind mic_irq_ctrl mic_irq_ctrl_monitor u_mic_irq_ctrl_monitor
(
  .REF_CLK(REF_CLK), .NRST(NRST), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
  .PADDR(PADDR), .PRDATA(PRDATA), .PSLVERR(PSLVERR), .EXT_PIN(EXT_PIN),
  .TICK0_EVT(TICK0_EVT), .TICK1_EVT(TICK1_EVT), .CONV_DONE(CONV_DONE),
  .NVM_DONE(NVM_DONE), .CMP_EVT(CMP_EVT), .CORE_NEXT_PC(CORE_NEXT_PC),
  .STACK_FULL(STACK_FULL), .RETI_EXEC(RETI_EXEC), .CORE_CMD(CORE_CMD), .WAKE(WAKE)
);

// ==== verif/mic_irq_ctrl_bench.sv ====
/*
  Self-checking bench: APB master, event pulses and the core model.
  Assumes the 25 MHz clock and that CE is held high throughout.
*/
`timescale 1ns/10ps

module mic_irq_ctrl_bench;
  logic REF_CLK = '0, NRST = '0, CE = 1'h1, PSEL = '0, PENABLE = '0, PWRITE = '0;
  logic [7:0] PADDR = '0, d, ra, ev;
  logic [31:0] PWDATA = '0, PRDATA, q;
  logic PREADY, PSLVERR, EXT_PIN = '0, WAKE, STACK_FULL, RETI_EXEC, err;
  logic hold_full = '0, reti_req = '0;
  logic [8:0] evt = '0; // Source pulses, index by source, 7 and 8 are A matches.
  logic [11:0] CORE_NEXT_PC;
  mic_pkg::mic_cmp_evt_s CMP_EVT;
  mic_pkg::mic_core_cmd_s CORE_CMD;
  int bad_count = 0, tests_run = 0, wake_cnt = 0, i, k, sel, b;
  localparam logic [7:0] MASK [5] = '{8'h03, 8'h7F, 8'hFF, 8'h33, 8'h33};
  assign CMP_EVT = {evt[8], evt[3], evt[7], evt[1]};

  always #20 REF_CLK = ~REF_CLK;
  // Count wake pulses for the pre-set flag test.
  always @(posedge REF_CLK) if (WAKE === 1'h1) wake_cnt++;

  mic_irq_ctrl u_mic_irq_ctrl
  (
    .REF_CLK(REF_CLK), .NRST(NRST), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .EXT_PIN(EXT_PIN), .TICK0_EVT(evt[2]),
    .TICK1_EVT(evt[6]), .CONV_DONE(evt[4]), .NVM_DONE(evt[5]), .CMP_EVT(CMP_EVT),
    .CORE_NEXT_PC(CORE_NEXT_PC), .STACK_FULL(STACK_FULL), .RETI_EXEC(RETI_EXEC),
    .CORE_CMD(CORE_CMD), .WAKE(WAKE)
  );
  mic_core_model u_mic_core_model
  (
    .REF_CLK(REF_CLK), .NRST(NRST), .CORE_CMD(CORE_CMD), .hold_full(hold_full),
    .reti_req(reti_req), .CORE_NEXT_PC(CORE_NEXT_PC), .STACK_FULL(STACK_FULL),
    .RETI_EXEC(RETI_EXEC)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Compare one value, counting it.
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; it waits for ready however long that takes.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge REF_CLK);
    PSEL <= 1'h1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge REF_CLK);
    PENABLE <= 1'h1;
    @(posedge REF_CLK);
    while (PREADY !== 1'h1) @(posedge REF_CLK);
    q = PRDATA;
    err = PSLVERR;
    PSEL <= '0;
    PENABLE <= '0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    apb('0, a, '0);
    chk(q, {24'h0, e});
  endtask
  // Pulse one source; the pin source toggles the pin instead.
  task pulse(input int s);
    @(posedge REF_CLK);
    if (s == 0)
      EXT_PIN <= ~EXT_PIN;
    else
      evt[s] <= 1'h1;
    @(posedge REF_CLK);
    evt <= '0;
  endtask
  // Expect a service of source s or none; a service is then returned from.
  task svc(input int s, input logic yes);
    int n;
    for (n = 0; n < 30 && CORE_CMD.push_stb !== 1'h1; n++) @(negedge REF_CLK);
    chk(CORE_CMD.push_stb, yes);
    if (yes)
    begin
      @(negedge REF_CLK);
      chk({CORE_CMD.load_stb, CORE_CMD.load_addr}, {1'h1, 12'h004 + 12'h004 * 12'(s)});
      @(posedge REF_CLK);
      reti_req <= 1'h1;
      @(posedge REF_CLK);
      reti_req <= '0;
    end
    else
      @(posedge REF_CLK); // Hand back on a rising edge so stimulus stays edge aligned.
  endtask
  task close_out;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // A full run is a few hundred cycles; the watchdog allows far more.
  initial
  begin
    #2000000;
    bad_count++;
    close_out();
  end

  initial
  begin
    void'($urandom(15707));
    repeat (8) @(posedge REF_CLK);
    NRST <= 1'h1;
    for (i = 0; i < 5; i++) rd(8'(4 * i), 8'h00);
    apb('0, 8'h14, '0);
    chk({q[7:0], err}, 9'h001);
    for (k = 0; k < 6; k++)
      for (i = 0; i < 5; i++)
      begin
        d = 8'($urandom);
        if (i == 1) d[0] = '0;
        apb(1'h1, 8'(4 * i), {24'h0, d});
        rd(8'(4 * i), d & MASK[i]);
      end
    for (i = 0; i < 5; i++) apb(1'h1, 8'(4 * i), '0);
    $display("test done: registers");
    // Every source taken once, group sources by P or A match at random.
    apb(1'h1, 8'h00, {30'h0, mic_pkg::EDGE_BOTH});
    for (i = 0; i < 7; i++)
    begin
      sel = $urandom % 2;
      b = ((i == 1 || i == 3) && sel == 1) ? 6 + (i + 1) / 2 : i;
      ra = mic_pkg::SRC_IN_CTRL1[i] ? 8'h08 : 8'h04;
      ev = 8'h01 << mic_pkg::SRC_EN_BIT[i];
      apb(1'h1, ra, {24'h0, ev | {7'h0, ra == 8'h04}});
      if (ra == 8'h08) apb(1'h1, 8'h04, 32'h1);
      pulse(b);
      svc(i, 1'h1);
      rd(ra, ev);
      rd(8'h04, ra == 8'h04 ? ev : 8'h00);
      if (i == 1 || i == 3) rd(i == 1 ? 8'h0C : 8'h10, 8'h10 << sel);
      for (k = 1; k < 5; k++) apb(1'h1, 8'(4 * k), '0);
    end
    $display("test done: service");
    apb(1'h1, 8'h04, 32'h1);
    pulse(4);
    svc(4, '0);
    rd(8'h08, 8'h40);
    apb(1'h1, 8'h04, '0);
    apb(1'h1, 8'h08, 32'h44);
    svc(4, '0);
    hold_full <= 1'h1;
    apb(1'h1, 8'h04, 32'h1);
    svc(4, '0);
    hold_full <= '0;
    svc(4, 1'h1);
    apb(1'h1, 8'h08, 32'h66);
    apb(1'h1, 8'h04, 32'h1);
    svc(4, 1'h1);
    apb(1'h1, 8'h04, 32'h1);
    svc(5, 1'h1);
    rd(8'h08, 8'h06);
    $display("test done: blocking and priority");
    apb(1'h1, 8'h08, 32'h40);
    wake_cnt = 0;
    pulse(4);
    repeat (4) @(posedge REF_CLK);
    chk(wake_cnt, 0);
    apb(1'h1, 8'h08, '0);
    wake_cnt = 0;
    pulse(4);
    repeat (4) @(posedge REF_CLK);
    chk(wake_cnt, 1);
    apb(1'h1, 8'h08, '0);
    $display("test done: wake");
    // Each edge code against a rise and a fall of the pin.
    for (i = 0; i < 4; i++)
      for (k = 0; k < 2; k++)
      begin
        apb(1'h1, 8'h00, i);
        pulse(0);
        repeat (6) @(posedge REF_CLK);
        rd(8'h04, (EXT_PIN ? i[0] : i[1]) ? 8'h10 : 8'h00);
        apb(1'h1, 8'h04, '0);
      end
    $display("test done: edge select");
    close_out();
  end
endmodule
